// file: ibmp_cfg.svh
`ifndef IBMP_CFG_SVH
`define IBMP_CFG_SVH

// system clock
`define IBMP_CLK_NS          10

// scl period is this many clocks per (1 + divider)
`define IBMP_SCL_DIV_UNIT    8
`define IBMP_STD_PERIOD_NS   10000
`define IBMP_FAST_PERIOD_NS  2500
`define IBMP_UNIT_NS         (`IBMP_SCL_DIV_UNIT * `IBMP_CLK_NS)
`define IBMP_STD_MIN_DIV     ((`IBMP_STD_PERIOD_NS + `IBMP_UNIT_NS - 1) / `IBMP_UNIT_NS - 1)
`define IBMP_FAST_MIN_DIV    ((`IBMP_FAST_PERIOD_NS + `IBMP_UNIT_NS - 1) / `IBMP_UNIT_NS - 1)

// bus free time after a stop
`define IBMP_BUF_NS          4700
`define IBMP_BUF_CYC         ((`IBMP_BUF_NS + `IBMP_CLK_NS - 1) / `IBMP_CLK_NS)
`define IBMP_BUF_W           10

// quarter phases of one bit slot
`define IBMP_Q_LOW           2'h0
`define IBMP_Q_RISE          2'h1
`define IBMP_Q_WAIT          2'h2
`define IBMP_Q_HIGH          2'h3

`define IBMP_BYTE_W          8
`define IBMP_LAST_BIT        3'h7
`define IBMP_FIFO_DEPTH      16
`define IBMP_SYNC_W          2

`endif

// file: ibmp_pkg.sv
package ibmp_pkg;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_START  = 8'h02,
        ST_BYTE   = 8'h04,
        ST_ACK    = 8'h08,
        ST_FETCH  = 8'h10,
        ST_HOLD   = 8'h20,
        ST_STOP   = 8'h40,
        ST_RSTART = 8'h80
    } ibmp_state_t;

endpackage

// file: ibmp_sync.sv
`timescale 1ns/100ps

module ibmp_sync #(
    parameter int W = 2
) (
    input  wire logic         sys_clk_in, // system clock
    input  wire logic         rstn_in,    // sync reset, active low
    input  wire logic [W-1:0] async_in,   // pin levels
    output logic      [W-1:0] sync_out    // synchronised levels
);

    logic [W-1:0] meta;

    // lines idle high, so reset to released
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// file: ibmp_fifo.sv
`timescale 1ns/100ps

module ibmp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_in,    // system clock
    input  wire logic             rstn_in,       // sync reset, active low
    input  wire logic [WIDTH-1:0] in_data_in,    // write word
    input  wire logic             in_valid_in,   // write request
    output logic                  in_ready_out,  // not full
    output logic      [WIDTH-1:0] out_data_out,  // head word
    output logic                  out_valid_out, // not empty
    input  wire logic             out_ready_in   // head taken
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire              do_wr      = in_valid_in & in_ready_out;
    wire              do_rd      = out_valid_out & out_ready_in;
    wire [AW:0]       next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);

    assign out_data_out = mem[rd_ptr];

    always_ff @(posedge sys_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // flags registered from the next count so both stay honest
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            wr_ptr        <= '0;
            rd_ptr        <= '0;
            count         <= '0;
            in_ready_out  <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            wr_ptr        <= wr_ptr + AW'(do_wr);
            rd_ptr        <= rd_ptr + AW'(do_rd);
            count         <= next_count;
            in_ready_out  <= next_count != (AW+1)'(DEPTH);
            out_valid_out <= next_count != '0;
        end
    end

endmodule

// file: ibmp_two_wire_master_unit.sv
// Contract
// - data line changes only while clock is low, stable during clock high
// - start: data falls while clock is high
// - stop: data rises while clock is high
// - bus busy from a start, free only a set time after a stop
// - bus idle only when data and clock are both sensed high
// - a new transfer begins only on a free bus
// - every byte is eight bits, any number of bytes per transfer
// - bytes go out most significant bit first
// - one clock per data bit plus a ninth for acknowledge
// - transmitter releases data during the acknowledge clock
// - acknowledging receiver holds data low through acknowledge high phase
// - missing address acknowledge lets the master abort with a stop
// - receiving master leaves the last byte's acknowledge high
// - master waits while the clock is held low, then continues
// - clock low lasts as the longest driver, high ends with the shortest
// - sending high but sensing low during clock high loses arbitration
// - after a loss, clocks continue only to the end of that byte
// - after start send seven address bits and a direction bit
// - every transfer ends with a stop made by the master
// - repeated start addresses another slave without a stop
// - lines are only pulled low or released, never driven high
// - bit rate at most 100 kbit/s standard, 400 kbit/s fast
// - clock period is eight times one plus divider system clocks
// - run, start and stop bits command the operations
// - acknowledge enable picks automatic acknowledge or a high slot
`timescale 1ns/100ps
`include "ibmp_cfg.svh"

module ibmp_two_wire_master_unit
    import ibmp_pkg::*;
(
    input  wire logic       sys_clk_in,                // system clock, 100 MHz
    input  wire logic       rstn_in,                   // sync reset, active low
    input  wire logic       cmd_write_in,              // command strobe, one cycle
    input  wire logic       cmd_run_in,                // run bit
    input  wire logic       cmd_start_in,              // start / repeated start bit
    input  wire logic       cmd_stop_in,               // stop after this byte
    input  wire logic       cmd_ack_in,                // acknowledge enable
    input  wire logic       high_speed_select_in,      // fast mode rate limit
    input  wire logic [6:0] slave_addr_in,             // slave address
    input  wire logic       dir_read_in,               // direction, 1 = read
    input  wire logic [7:0] clock_divider_register_in, // scl divider
    input  wire logic [7:0] tx_data_in,                // byte to send
    input  wire logic       tx_valid_in,               // byte offered
    output wire logic       tx_ready_out,              // fifo has room
    output logic      [7:0] rx_data_out,               // received byte
    output logic            rx_valid_out,              // received pulse
    input  wire logic       sda_in,                    // data pin level
    output logic            sda_out,                   // data pin drive value
    output logic            sda_oe_out,                // data pin pulled low
    input  wire logic       scl_in,                    // clock pin level
    output logic            scl_out,                   // clock pin drive value
    output logic            scl_oe_out,                // clock pin pulled low
    output logic            busy_out,                  // engine active
    output logic            bus_busy_out,              // bus not free: start seen, stop free time running, or a line low
    output logic            tx_mode_out,               // holding as transmitter
    output logic            rx_mode_out,               // holding as receiver
    output logic            done_out,                  // operation finished
    output logic            addr_nack_out,             // address not acknowledged
    output logic            data_nack_out,             // data not acknowledged
    output logic            arb_lost_out,              // arbitration lost
    output logic            cmd_refused_out,           // last command was not taken
    output logic            irq_out                    // interrupt request
);

    function automatic logic sda_edge(input logic prev, input logic cur,
                                      input logic scl_hi, input logic rising);
        sda_edge = scl_hi & (rising ? (~prev & cur) : (prev & ~cur));
    endfunction

    ibmp_state_t             state;
    logic [1:0]              q;
    logic [2:0]              bitn;
    logic [`IBMP_BYTE_W-1:0] shreg;
    logic                    is_addr;
    logic                    rd_mode;
    logic                    ack_en;
    logic                    stop_pend;
    logic                    arb_lost;
    logic                    got_ack;
    logic                    ev_done;
    logic                    ev_anack;
    logic                    ev_dnack;
    logic                    ev_arb;
    logic [8:0]              qcnt;
    logic                    sda_d;
    logic                    scl_d;
    logic                    bus_busy;
    logic [`IBMP_BUF_W-1:0]  buf_cnt;
    logic [1:0]              lines;
    logic [7:0]              fifo_data;
    logic                    fifo_valid;

    ibmp_sync #(
        .W (`IBMP_SYNC_W)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   ({scl_in, sda_in}),
        .sync_out   (lines)
    );

    wire scl_s = lines[1];
    wire sda_s = lines[0];

    // line monitor
    wire start_seen = sda_edge(sda_d, sda_s, scl_s & scl_d, 1'b0);
    wire stop_seen  = sda_edge(sda_d, sda_s, scl_s & scl_d, 1'b1);
    wire bus_free   = ~bus_busy & (buf_cnt == '0) & sda_s & scl_s;

    // command decode
    wire cmd_forbid = cmd_run_in & cmd_start_in & cmd_stop_in & cmd_ack_in & dir_read_in;
    wire cmd_begin  = cmd_write_in & cmd_run_in & cmd_start_in & ~cmd_forbid;
    wire cmd_next   = cmd_write_in & cmd_run_in & ~cmd_start_in;
    wire cmd_halt   = cmd_write_in & ~cmd_run_in & ~cmd_start_in & cmd_stop_in;
    wire in_idle    = state == ST_IDLE;
    wire in_hold    = state == ST_HOLD;
    wire cmd_taken  = (in_idle & cmd_begin) | (in_hold & (cmd_begin | cmd_next | cmd_halt));

    // rate: divider clamped to the mode's minimum
    wire [7:0] min_div = high_speed_select_in ? 8'(`IBMP_FAST_MIN_DIV)
                                              : 8'(`IBMP_STD_MIN_DIV);
    wire [7:0] eff_div = (clock_divider_register_in < min_div) ? min_div
                                                               : clock_divider_register_in;
    // a quarter bit is 2*(1+div) clocks, so four make 8*(1+div)
    wire [8:0] reload   = {eff_div, 1'b1};
    wire       scl_wait = (q == `IBMP_Q_WAIT) & ~scl_s;
    wire       hold_div = in_idle | in_hold | (state == ST_FETCH) | scl_wait;
    wire       tick     = (qcnt == '0) & ~hold_div;

    wire       tx_slot  = is_addr | ~rd_mode;
    wire       slot_end = (q == `IBMP_Q_HIGH) & (tick | ~scl_s);
    wire       sample   = (q == `IBMP_Q_WAIT) & tick;
    wire       fetch_tx = (state == ST_FETCH) & ~rd_mode & fifo_valid;

    ibmp_fifo #(
        .WIDTH (`IBMP_BYTE_W),
        .DEPTH (`IBMP_FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk_in    (sys_clk_in),
        .rstn_in       (rstn_in),
        .in_data_in    (tx_data_in),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (tx_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fetch_tx)
    );

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in || hold_div || tick) begin
            qcnt <= reload;
        end else begin
            qcnt <= qcnt - 9'h001;
        end
    end

    // own stop restarts the free timer too, so back to back starts respect it
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            sda_d    <= 1'b1;
            scl_d    <= 1'b1;
            bus_busy <= 1'b0;
            buf_cnt  <= '0;
        end else begin
            sda_d <= sda_s;
            scl_d <= scl_s;
            if (start_seen) begin
                bus_busy <= 1'b1;
                buf_cnt  <= '0;
            end else if (stop_seen) begin
                bus_busy <= 1'b0;
                buf_cnt  <= `IBMP_BUF_W'(`IBMP_BUF_CYC);
            end else if (buf_cnt != '0) begin
                buf_cnt <= buf_cnt - `IBMP_BUF_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            state        <= ST_IDLE;
            q            <= `IBMP_Q_LOW;
            bitn         <= 3'h0;
            shreg        <= '0;
            is_addr      <= 1'b0;
            rd_mode      <= 1'b0;
            ack_en       <= 1'b0;
            stop_pend    <= 1'b0;
            arb_lost     <= 1'b0;
            got_ack      <= 1'b0;
            sda_oe_out   <= 1'b0;
            scl_oe_out   <= 1'b0;
            rx_data_out  <= '0;
            rx_valid_out <= 1'b0;
            ev_done      <= 1'b0;
            ev_anack     <= 1'b0;
            ev_dnack     <= 1'b0;
            ev_arb       <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            ev_done      <= 1'b0;
            ev_anack     <= 1'b0;
            ev_dnack     <= 1'b0;
            ev_arb       <= 1'b0;
            if (cmd_taken && cmd_begin) begin
                shreg     <= {slave_addr_in, dir_read_in};
                is_addr   <= 1'b1;
                rd_mode   <= dir_read_in;
                arb_lost  <= 1'b0;
            end
            if (cmd_taken) begin
                ack_en    <= cmd_ack_in;
                stop_pend <= cmd_stop_in;
            end
            unique case (state)
                ST_IDLE: begin
                    sda_oe_out <= 1'b0;
                    scl_oe_out <= 1'b0;
                    q          <= `IBMP_Q_LOW;
                    if (cmd_taken) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (q == `IBMP_Q_LOW) begin
                        if (tick && bus_free) begin
                            sda_oe_out <= 1'b1;
                            q          <= `IBMP_Q_RISE;
                        end
                    end else if (tick) begin
                        q <= q + 2'h1;
                        if (q == `IBMP_Q_WAIT) begin
                            scl_oe_out <= 1'b1;
                            q          <= `IBMP_Q_LOW;
                            bitn       <= 3'h0;
                            state      <= ST_BYTE;
                        end
                    end
                end
                ST_FETCH: begin
                    bitn <= 3'h0;
                    if (rd_mode) begin
                        state <= ST_BYTE;
                    end else if (fifo_valid) begin
                        shreg <= fifo_data;
                        state <= ST_BYTE;
                    end
                end
                ST_HOLD: begin
                    sda_oe_out <= 1'b0;
                    q          <= `IBMP_Q_LOW;
                    if (cmd_taken) begin
                        if (cmd_begin) begin
                            state <= ST_RSTART;
                        end else if (cmd_next) begin
                            state <= ST_FETCH;
                        end else begin
                            state <= ST_STOP;
                        end
                    end
                end
                default: begin
                    // shared slot walk: low, release, wait high, high
                    if (q == `IBMP_Q_LOW && tick) begin
                        q <= `IBMP_Q_RISE;
                        unique case (state)
                            ST_BYTE:   sda_oe_out <= tx_slot & ~shreg[7] & ~arb_lost;
                            ST_ACK:    sda_oe_out <= ~tx_slot & ack_en;
                            ST_STOP:   sda_oe_out <= 1'b1;
                            default:   sda_oe_out <= 1'b0;
                        endcase
                    end
                    if (q == `IBMP_Q_RISE && tick) begin
                        scl_oe_out <= 1'b0;
                        q          <= `IBMP_Q_WAIT;
                    end
                    if (sample) begin
                        q <= `IBMP_Q_HIGH;
                        if (state == ST_BYTE) begin
                            shreg <= {shreg[6:0], sda_s};
                            if (tx_slot && shreg[7] && !sda_s && !arb_lost) begin
                                arb_lost   <= 1'b1;
                                sda_oe_out <= 1'b0;
                            end
                        end
                        if (state == ST_ACK) begin
                            got_ack <= ~sda_s;
                        end
                    end
                    if (slot_end && state == ST_STOP) begin
                        if (tick) begin
                            sda_oe_out <= 1'b0;
                            ev_done    <= 1'b1;
                            state      <= ST_IDLE;
                        end
                    end else if (slot_end && state == ST_RSTART) begin
                        if (tick) begin
                            sda_oe_out <= 1'b1;
                            q          <= `IBMP_Q_RISE;
                            state      <= ST_START;
                        end
                    end else if (slot_end) begin
                        scl_oe_out <= 1'b1;
                        q          <= `IBMP_Q_LOW;
                        if (state == ST_BYTE) begin
                            bitn <= bitn + 3'h1;
                            if (bitn == `IBMP_LAST_BIT) begin
                                if (arb_lost) begin
                                    scl_oe_out <= 1'b0;
                                    sda_oe_out <= 1'b0;
                                    ev_arb     <= 1'b1;
                                    ev_done    <= 1'b1;
                                    state      <= ST_IDLE;
                                end else begin
                                    state <= ST_ACK;
                                end
                            end
                        end else begin
                            is_addr <= 1'b0;
                            if (!tx_slot) begin
                                rx_data_out  <= shreg;
                                rx_valid_out <= 1'b1;
                            end
                            ev_anack <= is_addr & ~got_ack;
                            ev_dnack <= ~is_addr & ~rd_mode & ~got_ack;
                            if (is_addr && got_ack) begin
                                state <= ST_FETCH;
                            end else if (stop_pend) begin
                                state <= ST_STOP;
                            end else begin
                                ev_done <= 1'b1;
                                state   <= ST_HOLD;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // sticky flags cleared by the next command; a same-cycle event still sets
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            done_out        <= 1'b0;
            addr_nack_out   <= 1'b0;
            data_nack_out   <= 1'b0;
            arb_lost_out    <= 1'b0;
            irq_out         <= 1'b0;
            cmd_refused_out <= 1'b0;
        end else begin
            done_out      <= ev_done | (done_out & ~cmd_write_in);
            addr_nack_out <= ev_anack | (addr_nack_out & ~cmd_write_in);
            data_nack_out <= ev_dnack | (data_nack_out & ~cmd_write_in);
            arb_lost_out  <= ev_arb | (arb_lost_out & ~cmd_write_in);
            irq_out       <= ev_done | (irq_out & ~cmd_write_in);
            if (cmd_write_in) begin
                cmd_refused_out <= ~cmd_taken;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            sda_out      <= 1'b0;
            scl_out      <= 1'b0;
            busy_out     <= 1'b0;
            bus_busy_out <= 1'b0;
            tx_mode_out  <= 1'b0;
            rx_mode_out  <= 1'b0;
        end else begin
            sda_out      <= 1'b0;
            scl_out      <= 1'b0;
            busy_out     <= ~in_idle;
            bus_busy_out <= ~bus_free;
            tx_mode_out  <= in_hold & ~rd_mode;
            rx_mode_out  <= in_hold & rd_mode;
        end
    end

endmodule

// file: ibmp_chk.sv
`timescale 1ns/100ps
module ibmp_chk (
    input wire logic sys_clk_in,     // clock
    input wire logic rstn_in,        // reset
    input wire logic cmd_write_in,   // strobe
    input wire logic cmd_run_in,     // run
    input wire logic cmd_start_in,   // start
    input wire logic cmd_stop_in,    // stop
    input wire logic cmd_ack_in,     // ack
    input wire logic dir_read_in,    // read
    input wire logic sda_in,         // data
    input wire logic scl_in,         // clock
    input wire logic sda_out,        // value
    input wire logic scl_out,        // value
    input wire logic sda_oe_out,     // pull
    input wire logic scl_oe_out,     // pull
    input wire logic busy_out,       // busy
    input wire logic done_out,       // done
    input wire logic irq_out,        // irq
    input wire logic cmd_refused_out // refused
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    wire nop = cmd_write_in && !cmd_run_in && !cmd_start_in && !cmd_stop_in;
    wire bad = cmd_write_in && &{cmd_run_in, cmd_start_in, cmd_stop_in, cmd_ack_in, dir_read_in};
    sequence s_start; $rose(sda_oe_out) && !scl_oe_out; endsequence
    // released clock still low: someone else is holding it
    sequence s_held; !scl_oe_out && !scl_in ##1 !scl_oe_out && !scl_in; endsequence
    a_pins_low_only: assert property (!sda_out && !scl_out)
        else $error("line driven high");
    a_irq_done_same: assert property (irq_out == done_out)
        else $error("irq and done differ");
    a_nop_refused: assert property (nop |=> cmd_refused_out)
        else $error("nop taken");
    a_bad_refused: assert property (bad |=> cmd_refused_out)
        else $error("forbidden taken");
    a_start_on_free: assert property (s_start |-> scl_in && $past(sda_in))
        else $error("start on busy bus");
    a_stop_clock_high: assert property ($fell(sda_oe_out) && !scl_oe_out |-> scl_in)
        else $error("stop with clock low");
    a_stretch_holds: assert property (s_held |-> $stable(sda_oe_out))
        else $error("data moved while held");
    a_idle_released: assert property (!busy_out && $past(!busy_out) |-> !sda_oe_out && !scl_oe_out)
        else $error("idle engine holds bus");
endmodule
bind ibmp_two_wire_master_unit ibmp_chk u_chk (.*);

// file: ibmp_slave_model.sv
`timescale 1ns/100ps
module ibmp_slave_model (
    input  wire logic       scl_in,     // clock
    input  wire logic       sda_in,     // data
    input  wire logic       ack_en_in,  // answer
    input  wire logic [7:0] rd_byte_in, // read byte
    output logic            sda_oe_out, // pull
    output logic      [7:0] got_out,    // byte seen
    output logic            got_stb_out // seen
);
    int         bit_n = 0;
    int         byte_n = 0;
    logic       rd = 0;
    logic       quiet = 0;
    logic [7:0] sh = 8'h00;
    initial begin
        sda_oe_out = 0;
        got_stb_out = 0;
    end
    always @(negedge sda_in) if (scl_in === 1'b1) begin
        bit_n = 0;
        byte_n = 0;
        rd = 0;
        quiet = 0;
    end
    always @(posedge scl_in) begin
        if (bit_n < 8) begin
            sh = {sh[6:0], sda_in};
            bit_n++;
            got_out = sh;
            got_stb_out = (bit_n == 8);
            #1 got_stb_out = 0;
        end else begin
            if (byte_n == 0) rd = sh[0];
            quiet = rd && byte_n > 0 && sda_in;
            bit_n = 0;
            byte_n++;
        end
    end
    // only after the clock falls, so data is steady while high
    always @(negedge scl_in) begin
        if (bit_n == 8) sda_oe_out = ack_en_in && !(rd && byte_n > 0);
        else if (rd && byte_n > 0 && !quiet) sda_oe_out = ~rd_byte_in[7 - bit_n];
        else sda_oe_out = 0;
    end
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
    logic        sys_clk_in = 0, rstn_in = 0, cmd_write_in = 0, tx_valid_in = 0, scl_hold = 0;
    logic        high_speed_select_in = 1, ack_en = 1;
    logic [4:0]  cmd = 5'h00;
    logic [6:0]  slave_addr_in = 7'h00;
    logic [7:0]  clock_divider_register_in = 8'h00, tx_data_in = 8'h00, rd_byte = 8'h00;
    logic [7:0]  got, rx_data_out, exp_q[$];
    logic [31:0] lfsr = 32'hd7a7;
    int          mismatches = 0, total_checks = 0;
    logic        tx_ready_out, rx_valid_out, sda_out, sda_oe_out, scl_out, scl_oe_out, busy_out;
    logic        bus_busy_out, tx_mode_out, rx_mode_out, done_out, addr_nack_out, data_nack_out;
    logic        arb_lost_out, cmd_refused_out, irq_out, slv_oe, got_stb;
    wire         dir_read_in, cmd_ack_in, cmd_stop_in, cmd_start_in, cmd_run_in;
    wire         sda_in = ~(sda_oe_out | slv_oe);
    wire         scl_in = ~(scl_oe_out | scl_hold);
    assign {dir_read_in, cmd_ack_in, cmd_stop_in, cmd_start_in, cmd_run_in} = cmd;
    ibmp_two_wire_master_unit dut (.*);
    ibmp_slave_model slave (.scl_in(scl_in), .sda_in(sda_in), .ack_en_in(ack_en),
        .rd_byte_in(rd_byte), .sda_oe_out(slv_oe), .got_out(got), .got_stb_out(got_stb));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic issue(input logic [4:0] c);
        int n;
        n = 0;
        cmd = c;
        cmd_write_in = 1;
        @(negedge sys_clk_in);
        cmd_write_in = 0;
        while (done_out !== 1'b1 && !(n > 4 && busy_out === 1'b0) && n < 30000) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n >= 30000) mismatches++;
    endtask
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge got_stb) check("wire byte", got, exp_q.pop_front());
    always @(negedge sys_clk_in) if (rx_valid_out === 1'b1) begin
        check("rx byte", rx_data_out, exp_q.pop_front());
    end
    initial begin
        repeat (90000) @(posedge sys_clk_in);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (6) @(negedge sys_clk_in);
        rstn_in = 1;
        @(negedge sys_clk_in);
        issue(5'b00000);
        check("nop", {7'h00, cmd_refused_out}, 8'h01);
        issue(5'b11111);
        check("forbidden", {7'h00, cmd_refused_out}, 8'h01);
        lfsr = lfsr_next(lfsr);
        slave_addr_in = lfsr[6:0];
        exp_q.push_back({lfsr[6:0], 1'b0});
        tx_valid_in = 1;
        repeat (16) begin
            lfsr = lfsr_next(lfsr);
            tx_data_in = lfsr[7:0];
            exp_q.push_back(lfsr[7:0]);
            @(negedge sys_clk_in);
        end
        tx_valid_in = 0;
        check("full", {7'h00, tx_ready_out}, 8'h00);
        fork
            begin
                repeat (3000) @(negedge sys_clk_in);
                @(negedge scl_in);
                @(negedge sys_clk_in);
                scl_hold = 1;
                repeat (400) @(negedge sys_clk_in);
                scl_hold = 0;
            end
        join_none
        issue(5'b00011);
        check("tx mode", {6'h00, rx_mode_out, tx_mode_out}, 8'h01);
        repeat (15) issue(5'b00001);
        check("drained", {7'h00, tx_ready_out}, 8'h01);
        lfsr = lfsr_next(lfsr);
        slave_addr_in = lfsr[6:0];
        rd_byte = lfsr[15:8];
        clock_divider_register_in = 8'h2f;
        exp_q.push_back({lfsr[6:0], 1'b1});
        exp_q.push_back(lfsr[15:8]);
        exp_q.push_back(lfsr[15:8]);
        issue(5'b10111);
        @(negedge sys_clk_in);
        check("busy", {6'h00, bus_busy_out, busy_out}, 8'h02);
        ack_en = 0;
        high_speed_select_in = 0;
        exp_q.push_back({slave_addr_in, 1'b0});
        issue(5'b00111);
        check("addr nack", {5'h00, addr_nack_out, data_nack_out, arb_lost_out}, 8'h04);
        check("left", 8'(exp_q.size()), 8'h00);
        end_of_test();
    end
endmodule
